// [sar_seq_regs.svh]
`ifndef SAR_SEQ_REGS_SVH
`define SAR_SEQ_REGS_SVH

// reference clock rate, 50 MHz
`define REF_CLK_HZ      32'h02fa_f080
// fastest converter clock allowed, 18 MHz
`define SAR_CLK_MAX_HZ  32'h0112_a880
// least converter clocks per full conversion
`define CONV_MIN_CLKS   8'h12
// result width and channel count
`define RESULT_BITS     12
`define CHANNELS        8
// shortest acquisition window, converter clocks
`define SAMPLE_MIN      8'h04
// converter clocks spent latching a result
`define STORE_CLKS      8'h02

`endif

// [sar_seq_pkg.sv]
`include "sar_seq_regs.svh"

package sar_seq_pkg;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b10,
		ST_STORE   = 2'b11
	} seq_state_t;

	// acquisition length per channel, in converter clocks
	typedef logic [7:0] samp_time_t;

	// one finished conversion as it leaves the block
	typedef struct packed {
		logic [2:0]              channel;
		logic                    out_of_range;
		logic [`RESULT_BITS-1:0] value;
	} result_t;

endpackage

// [sar_seq_ctrl.sv]
// Behaviour
// RULE1 - a conversion takes at least 18 converter clocks, clock at most 18 MHz
// RULE2 - results are 12 bits at up to one million samples per second; the divide-by-3 converter clock tops out near 926 thousand
// RULE3 - the sequencer picks among eight fixed input channels
// RULE4 - a started scan walks all enabled channels without software help
// RULE5 - moving to the next channel costs no idle converter clocks
// RULE6 - channel comes from the scan machine or from direct firmware choice
// RULE7 - every channel keeps its own result buffer
// RULE8 - each channel converts with its own programmed sample time
// RULE9 - results outside the low/high limits raise an out-of-range interrupt
// RULE10 - that indication rises when the offending conversion completes
// RULE11 - the acquisition window length is programmable for slow sources
// RULE12 - no conversions run in deep sleep
// RULE13 - a scan-complete flag rises after the last channel, software clears
// RULE14 - results equal to a limit are in range
`timescale 1ns/10ps
`default_nettype none
`include "sar_seq_regs.svh"

module res_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;

	// handshakes and flags
	wire logic push = in_valid && in_ready;
	wire logic pop  = out_valid && out_ready;
	assign in_ready  = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data  = mem[rd_ptr_reg];

	// storage carries no reset, only the pointers matter
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointers wrap at depth, so depth need not be a power of two
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module sar_seq_ctrl #(
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// scan control
	input  wire logic                     enable,
	input  wire logic                     scan_start,
	input  wire logic                     continuous,
	input  wire logic                     manual_mode,
	input  wire logic [2:0]               manual_ch,
	input  wire logic [7:0]               chan_en,
	input  wire sar_seq_pkg::samp_time_t  samp_times [8],
	input  wire logic [11:0]              limit_low,
	input  wire logic [11:0]              limit_high,
	input  wire logic                     deep_sleep,
	// status
	output logic                          busy,
	output logic                          scan_done,
	input  wire logic                     scan_done_clr,
	output logic [7:0]                    range_flags,
	input  wire logic [7:0]               range_clr,
	output logic                          range_irq,
	// per-channel result buffers
	input  wire logic [2:0]               rd_ch,
	output logic [11:0]                   rd_data,
	// result stream
	output logic                          res_valid,
	input  wire logic                     res_ready,
	output sar_seq_pkg::result_t          res_data,
	// analog core
	output logic                          sar_clk,
	output logic                          samp_en,
	output logic [2:0]                    ch_sel,
	output logic [11:0]                   dac_code,
	input  wire logic                     cmp_in
);
	import sar_seq_pkg::*;

	// converter clock divider, rounded up so the rate never exceeds the limit
	localparam int DIV = (`REF_CLK_HZ + `SAR_CLK_MAX_HZ - 1) / `SAR_CLK_MAX_HZ;
	localparam int DW = $clog2(DIV + 1);
	localparam int MIN_CONV_CYC = `CONV_MIN_CLKS * DIV;

	seq_state_t state_reg, state_next;
	logic [DW-1:0] div_cnt_reg;
	logic          sar_clk_reg;
	logic          sleep_meta_reg, sleep_sync_reg;
	logic          cmp_meta_reg, cmp_sync_reg;
	logic [2:0]    cur_ch_reg, ch_next;
	logic [7:0]    cnt_reg, cnt_next;
	logic [3:0]    bit_reg, bit_next;
	logic [11:0]   sar_reg, sar_next;
	logic          scan_manual_reg, manual_next;
	logic          scan_done_reg;
	logic [7:0]    range_flags_reg, range_flags_next;
	logic          range_irq_reg;
	logic [11:0]   result_mem [`CHANNELS];
	logic [11:0]   rd_data_reg;
	logic          fifo_in_ready;
	result_t       fifo_in;
	logic [7:0]    conv_cyc_reg;

	// acquisition never shorter than the floor, keeping 18 clocks per result
	function automatic logic [7:0] eff_samp(input samp_time_t t);
		eff_samp = (t < `SAMPLE_MIN) ? `SAMPLE_MIN : t;
	endfunction

	// lowest enabled channel at or above from, with a found bit on top
	function automatic logic [3:0] next_en(input logic [7:0] m,
		input logic [3:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--)
			if (m[i] && 4'(i) >= from)
				r = {1'b1, 3'(i)};
		next_en = r;
	endfunction

	// divider produces one tick per converter clock
	wire logic tick = div_cnt_reg == DW'(DIV - 1); // RULE1

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			div_cnt_reg <= '0;
			sar_clk_reg <= 1'b0;
		end
		else
		begin
			div_cnt_reg <= tick ? '0 : div_cnt_reg + 1'b1;
			sar_clk_reg <= tick;
		end
	end

	// two-flop synchronisers for the sleep request and the comparator
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sleep_meta_reg <= 1'b0;
			sleep_sync_reg <= 1'b0;
			cmp_meta_reg   <= 1'b0;
			cmp_sync_reg   <= 1'b0;
		end
		else
		begin
			sleep_meta_reg <= deep_sleep;
			sleep_sync_reg <= sleep_meta_reg;
			cmp_meta_reg   <= cmp_in;
			cmp_sync_reg   <= cmp_meta_reg;
		end
	end

	// channel choice: scan walks the enable mask, manual takes firmware's pick
	wire logic [3:0] first_sel = next_en(chan_en, 4'h0); // RULE3
	wire logic [3:0] after_sel = next_en(chan_en, {1'b0, cur_ch_reg} + 4'h1);
	wire logic has_next = after_sel[3] && !scan_manual_reg; // RULE4
	wire logic [2:0] start_ch = manual_mode ? manual_ch : first_sel[2:0]; // RULE6
	wire logic can_start = manual_mode || first_sel[3];
	wire logic halt = !enable || sleep_sync_reg; // RULE12
	wire logic [2:0] next_ch = has_next ? after_sel[2:0]
		: (scan_manual_reg ? cur_ch_reg : first_sel[2:0]);
	wire logic cont_go = has_next
		|| (continuous && (scan_manual_reg || first_sel[3]));
	wire logic [7:0] load_val = eff_samp(samp_times[ch_next]); // RULE8 RULE11

	// one successive-approximation step; comparator high keeps the trial bit
	wire logic [11:0] bit_mask = 12'h001 << bit_reg;
	wire logic [11:0] sar_keep = cmp_sync_reg ? sar_reg : (sar_reg & ~bit_mask);
	wire logic [11:0] sar_step = (bit_reg == 4'h0) ? sar_keep
		: (sar_keep | (bit_mask >> 1));

	// window check, a value on a limit counts as inside
	wire logic oor_now = (sar_reg < limit_low) || (sar_reg > limit_high); // RULE14
	wire logic in_sample = state_reg == ST_SAMPLE;
	// a halt in the last store clock drops the result, as for any abort
	wire logic store_done = state_reg == ST_STORE && tick && cnt_reg == 8'h01
		&& !halt;
	wire logic commit = store_done && fifo_in_ready;

	// sequencer; a full fifo holds the result in store and stalls the scan
	always_comb
	begin
		state_next  = state_reg;
		ch_next     = cur_ch_reg;
		cnt_next    = cnt_reg;
		bit_next    = bit_reg;
		sar_next    = sar_reg;
		manual_next = scan_manual_reg;
		if (halt)
			state_next = ST_IDLE; // RULE12
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (scan_start && can_start && tick)
					begin
						state_next  = ST_SAMPLE;
						ch_next     = start_ch; // RULE6
						manual_next = manual_mode;
						cnt_next    = eff_samp(samp_times[start_ch]); // RULE8
					end
				ST_SAMPLE:
					if (tick)
					begin
						if (cnt_reg == 8'h01)
						begin
							state_next = ST_CONVERT;
							bit_next   = 4'hb;
							sar_next   = 12'h800;
						end
						else
							cnt_next = cnt_reg - 8'h01; // RULE11
					end
				ST_CONVERT:
					if (tick)
					begin
						sar_next = sar_step; // RULE2
						if (bit_reg == 4'h0)
						begin
							state_next = ST_STORE;
							cnt_next   = `STORE_CLKS;
						end
						else
							bit_next = bit_reg - 4'h1;
					end
				ST_STORE:
					if (commit)
					begin
						// next channel samples at once, no idle clock
						if (cont_go)
						begin
							state_next = ST_SAMPLE; // RULE4 RULE5
							ch_next    = next_ch;
							cnt_next   = eff_samp(samp_times[next_ch]); // RULE8
						end
						else
							state_next = ST_IDLE;
					end
					else if (tick && cnt_reg != 8'h01)
						cnt_next = cnt_reg - 8'h01;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg       <= ST_IDLE;
			cur_ch_reg      <= 3'h0;
			cnt_reg         <= 8'h00;
			bit_reg         <= 4'h0;
			sar_reg         <= 12'h000;
			scan_manual_reg <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			cur_ch_reg      <= ch_next;
			cnt_reg         <= cnt_next;
			bit_reg         <= bit_next;
			sar_reg         <= sar_next;
			scan_manual_reg <= manual_next;
		end
	end

	// per-channel buffers: software may read any channel at leisure
	always_ff @(posedge ref_clk)
	begin
		if (commit)
			result_mem[cur_ch_reg] <= sar_reg; // RULE7
	end

	// sticky flags; a new event wins over a clear in the same cycle
	assign range_flags_next = (range_flags_reg & ~range_clr)
		| ((commit && oor_now) ? (8'h01 << cur_ch_reg) : 8'h00); // RULE9 RULE10

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scan_done_reg   <= 1'b0;
			range_flags_reg <= 8'h00;
			range_irq_reg   <= 1'b0;
			rd_data_reg     <= 12'h000;
		end
		else
		begin
			scan_done_reg   <= (commit && !has_next)
				|| (scan_done_reg && !scan_done_clr); // RULE13
			range_flags_reg <= range_flags_next;
			range_irq_reg   <= |range_flags_next; // RULE9
			rd_data_reg     <= result_mem[rd_ch];
		end
	end

	// result stream through the fifo
	assign fifo_in = '{channel: cur_ch_reg, out_of_range: oor_now,
		value: sar_reg};

	res_fifo #(
		.WIDTH ($bits(result_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (store_done),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (res_valid),
		.out_ready (res_ready),
		.out_data  (res_data)
	);

	// outputs from flops; busy and samp_en are decoded from state_reg
	assign busy        = state_reg != ST_IDLE;
	assign scan_done   = scan_done_reg;
	assign range_flags = range_flags_reg;
	assign range_irq   = range_irq_reg;
	assign rd_data     = rd_data_reg;
	assign sar_clk     = sar_clk_reg;
	assign samp_en     = in_sample; // RULE11
	assign ch_sel      = cur_ch_reg; // RULE3
	assign dac_code    = sar_reg;

	// cycles since the current conversion began, checking only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			conv_cyc_reg <= 8'h00;
		else if (state_next == ST_SAMPLE && !in_sample)
			conv_cyc_reg <= 8'h01;
		else if (conv_cyc_reg != 8'hff)
			conv_cyc_reg <= conv_cyc_reg + 8'h01;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_acq_start;
		!in_sample ##1 in_sample;
	endsequence

	sequence s_last_commit;
		commit && !has_next;
	endsequence

	a_conv_min_len: // RULE1
		assert property (commit |-> conv_cyc_reg >= 8'(MIN_CONV_CYC))
		else $error("conversion shorter than the minimum");

	a_bit_walk: // RULE2
		assert property (state_reg == ST_CONVERT && tick && bit_reg != 4'h0
			&& !halt |=> bit_reg == $past(bit_reg) - 4'h1)
		else $error("approximation skipped a bit");

	a_zero_gap: // RULE4 RULE5
		assert property (commit && has_next && !halt |=> in_sample
			&& cur_ch_reg == $past(after_sel[2:0]))
		else $error("channel switch lost a clock or channel");

	a_manual_sel: // RULE6
		assert property (in_sample && $past(state_reg) == ST_IDLE
			&& $past(manual_mode) |-> cur_ch_reg == $past(manual_ch))
		else $error("manual channel not taken");

	a_buf_write: // RULE7
		assert property (commit |=> result_mem[$past(cur_ch_reg)]
			== $past(sar_reg))
		else $error("result buffer not written");

	a_samp_load: // RULE8
		assert property (in_sample && $past(state_reg) != ST_SAMPLE
			|-> cnt_reg == $past(load_val) && cnt_reg >= `SAMPLE_MIN)
		else $error("wrong sample time loaded");

	a_range_flag: // RULE9 RULE10
		assert property (commit && oor_now |=> range_flags_reg[$past(cur_ch_reg)]
			&& range_irq)
		else $error("out-of-range not flagged at once");

	a_acq_hold: // RULE11
		assert property (s_acq_start |-> (samp_en [*8]) or (##[0:7] halt))
		else $error("acquisition window cut short");

	a_sleep_halt: // RULE12
		assert property (sleep_sync_reg |=> state_reg == ST_IDLE)
		else $error("conversion running in sleep");

	a_scan_done: // RULE13
		assert property (s_last_commit |=> scan_done)
		else $error("scan complete not flagged");

	a_range_incl: // RULE14
		assert property (commit && sar_reg >= limit_low && sar_reg <= limit_high
			&& !range_flags_reg[cur_ch_reg] && !halt
			|=> !range_flags_reg[$past(cur_ch_reg)])
		else $error("in-range value flagged");
endmodule
`default_nettype wire

// [sar_core_model.sv]
`timescale 1ns/10ps
`default_nettype none

module sar_core_model (
	// converter side of the sequencer
	input  wire logic        ref_clk,
	input  wire logic        samp_en,
	input  wire logic [2:0]  ch_sel,
	input  wire logic [11:0] dac_code,
	// analog levels on the eight fixed inputs
	input  wire logic [11:0] ain [8],
	// comparator decision
	output logic             cmp_in
);
	logic [11:0] held_reg;

	initial held_reg = 12'h000;

	// track while sampling, then frozen; a short window would not settle a
	// real source, here it only picks the level of the selected channel
	always @(posedge ref_clk)
	begin
		if (samp_en)
			held_reg <= ain[ch_sel];
	end

	// comparator is unclocked, the sequencer has to synchronise it
	assign cmp_in = (held_reg >= dac_code);
endmodule

`default_nettype wire

// [sequenced_adc_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module sequenced_adc_control_tb_top;
	import sar_seq_pkg::*;
	// clock, reset, controls
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        enable = 1'b1, scan_start = 1'b0, manual_mode = 1'b0;
	logic [2:0]  manual_ch = 3'h0, rd_ch = 3'h0, ch_sel;
	logic [7:0]  chan_en = 8'h00, range_clr = 8'h00, range_flags;
	samp_time_t  samp_times [8];
	logic [11:0] limit_low = 12'h400, limit_high = 12'hc00, ain [8];
	logic        deep_sleep = 1'b0, scan_done_clr = 1'b0, res_ready = 1'b1;
	logic        continuous = 1'b0;
	logic        busy, scan_done, range_irq, res_valid, sar_clk, samp_en;
	logic        cmp_in;
	logic [11:0] rd_data, dac_code;
	result_t     res_data, pe;
	// bench model state
	result_t     exp_q [$];
	logic [7:0]  exp_mask;
	int          mismatches = 0, n_checks = 0, cyc = 0, start_cyc, last_pop;
	int          pc, pend_ch = -1;
	bit          chk_time = 1'b0, first_pop;

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	sar_seq_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .enable(enable),
		.scan_start(scan_start), .continuous(continuous),
		.manual_mode(manual_mode), .manual_ch(manual_ch), .chan_en(chan_en),
		.samp_times(samp_times), .limit_low(limit_low),
		.limit_high(limit_high), .deep_sleep(deep_sleep), .busy(busy),
		.scan_done(scan_done), .scan_done_clr(scan_done_clr),
		.range_flags(range_flags), .range_clr(range_clr),
		.range_irq(range_irq), .rd_ch(rd_ch), .rd_data(rd_data),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
		.sar_clk(sar_clk), .samp_en(samp_en), .ch_sel(ch_sel),
		.dac_code(dac_code), .cmp_in(cmp_in));

	sar_core_model i_core (.ref_clk(ref_clk), .samp_en(samp_en),
		.ch_sel(ch_sel), .dac_code(dac_code), .ain(ain), .cmp_in(cmp_in));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// window below 4 converter clocks is raised to 4
	function automatic int sdur(input int c);
		return (samp_times[c] < 8'h04) ? 4 : int'(samp_times[c]);
	endfunction

	task automatic results();
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// every popped word is compared with the head of the bench queue
	always @(posedge ref_clk)
	begin
		if (pend_ch >= 0)
		begin
			chk(16'(range_flags[pend_ch]), 16'h0001);
			chk(16'(range_irq), 16'h0001);
			pend_ch = -1;
		end
		if (!rst && res_valid === 1'b1 && res_ready)
		begin
			pc = cyc + 1;
			pe = (exp_q.size() > 0) ? exp_q.pop_front() : result_t'(16'hffff);
			chk(res_data, pe);
			if (pe.out_of_range)
				pend_ch = pe.channel;
			if (chk_time && first_pop)
				chk(16'(pc - start_cyc), 16'((sdur(pe.channel) + 14) * 3 + 1));
			else if (chk_time)
				chk(16'(pc - last_pop), 16'((sdur(pe.channel) + 14) * 3));
			first_pop = 1'b0;
			last_pop = pc;
		end
	end

	task automatic start_scan(input logic [7:0] en, input logic man,
		input logic [2:0] mch);
		int c;
		chan_en = en;
		manual_mode = man;
		manual_ch = mch;
		exp_mask = 8'h00;
		for (c = 0; c < 8; c++)
		begin
			if (man ? (c == mch) : en[c])
			begin
				pe.channel = 3'(c);
				pe.value = ain[c];
				pe.out_of_range = (ain[c] < limit_low) || (ain[c] > limit_high);
				exp_mask[c] = pe.out_of_range;
				exp_q.push_back(pe);
			end
		end
		scan_start = 1'b1;
		for (c = 0; c < 10 && busy !== 1'b1; c++)
			cycles(1);
		chk(16'(busy), 16'h0001);
		chk(16'({samp_en, ch_sel}), 16'({1'b1, exp_q[0].channel}));
		start_cyc = cyc;
		first_pop = 1'b1;
		scan_start = 1'b0;
	endtask

	task automatic finish_scan();
		int c;
		for (c = 0; c < 5000 && busy !== 1'b0; c++)
			cycles(1);
		cycles(3);
		chk(16'(exp_q.size()), 16'h0000);
		chk(16'(scan_done), 16'h0001);
		chk(16'(range_flags), 16'(exp_mask));
		chk(16'(range_irq), 16'(|exp_mask));
		for (c = 0; c < 8; c++)
		begin
			rd_ch = 3'(c);
			cycles(1);
			if (manual_mode ? (c == manual_ch) : chan_en[c])
				chk(16'(rd_data), 16'(ain[c]));
		end
		scan_done_clr = 1'b1;
		range_clr = 8'hff;
		cycles(1);
		scan_done_clr = 1'b0;
		range_clr = 8'h00;
		cycles(1);
		chk(16'({scan_done, range_irq, range_flags}), 16'h0000);
	endtask

	initial
	begin
		int i, k, n;
		void'($urandom(7));
		for (i = 0; i < 8; i++)
		begin
			ain[i] = 12'($urandom);
			samp_times[i] = 8'($urandom_range(15, 0));
		end
		cycles(3);
		rst = 1'b0;
		chk(16'({busy, scan_done, range_irq, res_valid, samp_en}), 16'h0000);
		chk(16'({range_flags, ch_sel}), 16'h0000);
		chk(16'(dac_code | rd_data), 16'h0000);
		n = 0;
		for (i = 0; i < 30; i++)
		begin
			cycles(1);
			n += sar_clk;
		end
		chk(16'(n), 16'h000a);
		chk_time = 1'b1;
		// random scans, then the limits themselves and one step past them
		for (k = 0; k < 4; k++)
		begin
			if (k == 3)
			begin
				ain[0] = 12'h400;
				ain[1] = 12'hc00;
				ain[2] = 12'h3ff;
				ain[3] = 12'hc01;
				ain[4] = 12'h000;
				ain[5] = 12'hfff;
			end
			start_scan((k == 3) ? 8'h3f : 8'($urandom_range(255, 1)),
				1'b0, 3'h0);
			finish_scan();
		end
		for (k = 0; k < 2; k++)
		begin
			start_scan(8'h00, 1'b1, 3'($urandom));
			finish_scan();
		end
		// continuous: the scan restarts at once, stopped in its second pass
		continuous = 1'b1;
		start_scan(8'($urandom_range(255, 1)), 1'b0, 3'h0);
		n = exp_q.size();
		for (i = 0; i < n; i++)
			exp_q.push_back(exp_q[i]);
		for (i = 0; i < 5000 && scan_done !== 1'b1; i++)
			cycles(1);
		chk(16'(busy), 16'h0001);
		continuous = 1'b0;
		finish_scan();
		// far side stalls: the four-word buffer fills and the scan waits
		chk_time = 1'b0;
		res_ready = 1'b0;
		start_scan(8'hff, 1'b0, 3'h0);
		cycles(1000);
		chk(16'({busy, res_valid}), 16'h0003);
		chk(16'(exp_q.size()), 16'h0008);
		res_ready = 1'b1;
		finish_scan();
		// abort by sleep and by disable; no word may appear afterwards
		for (k = 0; k < 2; k++)
		begin
			start_scan(8'hff, 1'b0, 3'h0);
			cycles(20);
			deep_sleep = (k == 0);
			enable = (k == 0);
			cycles(8);
			chk(16'(busy), 16'h0000);
			scan_start = 1'b1;
			cycles(100);
			chk(16'({busy, res_valid}), 16'h0000);
			chk(16'(exp_q.size()), 16'h0008);
			scan_start = 1'b0;
			exp_q.delete();
			deep_sleep = 1'b0;
			enable = 1'b1;
			cycles(5);
		end
		results();
	end

	// watchdog, well beyond the longest expected run
	initial
	begin
		#1500000;
		mismatches++;
		results();
	end
endmodule

`default_nettype wire
